// File: hdl/dsc_cfg.svh
// constants for the dual serial controller pin model
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
`define ADDR_W        6
`define DATA_W        8
`define DATA_MSB      7
`define CNT_W         4
`define BIT_LAST      4'h7
`define CNT_ZERO      4'h0
`define VEC_RESET     8'h0F
// synchroniser reset value matches the idle pin levels
`define SYNC_IDLE     12'hF80
// device register indices (6-bit address space)
`define REG_TXDATA    6'h00
`define REG_RXDATA    6'h01
`define REG_CTRL      6'h02
`define REG_STATUS    6'h03
`define REG_VECTOR    6'h04
// ctrl bits
`define CTRL_TX_EN    0
`define CTRL_CTS_EN   1
`define CTRL_LOOPBK   2
`define CTRL_LOOPM    3
`define CTRL_LC_ON    4
`define CTRL_CTS_IE   5
`define CTRL_VEC_MOD  6
`define CTRL_DAISY    7
// status bits
`define ST_RX_FULL    0
`define ST_CTS_CHG    1
`define ST_TX_BUSY    2
`define ST_CTS_LVL    3
// host apb register byte offsets
`define H_CMD         12'h000
`define H_WDATA       12'h004
`define H_RDATA       12'h008
`define H_STATUS      12'h00C
`define H_LINK        12'h010
// host link command bits
`define CMD_GO        0
`define CMD_READ      1
`define CMD_IACK      2
`define CMD_ADDR_LSB  8
`define CMD_ADDR_MSB  13
// last strobe count for host cycles; the strobe is held for 8 pclk cycles
`define STROBE_CYC    4'h6
`define CLKDIV_HALF   4'h3
`endif

// File: hdl/dsc_pkg.sv
// types for the dual serial controller pin model
package dsc_pkg;
    typedef enum logic [1:0]
    {
        HS_IDLE  = 2'b00,
        HS_SETUP = 2'b01,
        HS_STRB  = 2'b11,
        HS_DONE  = 2'b10
    } host_st_t;
endpackage : dsc_pkg

// File: hdl/dsc_if.sv
// pin carrier between host cpu and serial controller
`timescale 1ns/1ps
interface dsc_if;
    logic [5:0] addr;
    logic       read_not_write;
    logic       chip_select_n;
    logic       interrupt_ack_n;
    logic [7:0] data_host_out;
    logic       data_host_oe;
    logic [7:0] data_dev_out;
    logic       data_dev_oe;
    logic       interrupt_request_n_oe;
    logic       daisy_chain_n;
    logic       serial_in_chan_a;
    logic       serial_out_chan_a;
    logic       chan_clock_pin_one;
    logic       chan_clock_pin_two;
    logic       clear_to_send_n;
    logic       loop_control_n;
    logic       loop_control_oe;

    modport device
    (
        input  addr, read_not_write, chip_select_n, interrupt_ack_n,
               data_host_out, serial_in_chan_a, chan_clock_pin_one,
               clear_to_send_n,
        output data_dev_out, data_dev_oe, interrupt_request_n_oe,
               daisy_chain_n, serial_out_chan_a, chan_clock_pin_two,
               loop_control_n, loop_control_oe
    );
    modport host
    (
        output addr, read_not_write, chip_select_n, interrupt_ack_n,
               data_host_out, data_host_oe,
        input  data_dev_out, data_dev_oe, interrupt_request_n_oe
    );
endinterface : dsc_if

// File: hdl/sync2.sv
// two-flop synchroniser for a bundle of pins
`timescale 1ns/1ps
module sync2 #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r <= RST;
            q      <= RST;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : sync2

// File: hdl/dsc_device.sv
// serial controller device end: cpu pins and one serial channel
//
// Design decisions made here: register access over the cpu pins and the register addresses.
`timescale 1ns/1ps
`include "dsc_cfg.svh"
module dsc_device
    import dsc_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    dsc_if.device     pins,
    output logic      rx_strobe,
    output logic      tx_active
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [11:0] raw;
    logic [11:0] syn;
    assign raw = {pins.chip_select_n, pins.read_not_write,
                  pins.interrupt_ack_n, pins.clear_to_send_n,
                  pins.serial_in_chan_a, pins.chan_clock_pin_one,
                  pins.addr};
    sync2 #(.W(12), .RST(`SYNC_IDLE)) u_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (raw),
        .q       (syn)
    );
    logic [5:0] addr_s;
    logic cs_n_s, rnw_s, iack_n_s, cts_n_s, rxd_s, clk1_s;
    assign {cs_n_s, rnw_s, iack_n_s, cts_n_s, rxd_s, clk1_s, addr_s} = syn;

    // ------------------------------------------------------------
    // edge detection and registers
    // ------------------------------------------------------------
    logic       clk1_d_r, cts_d_r, cs_d_r;
    logic [7:0] ctrl_r, vector_r, txdata_r, rxdata_r, rxsh_r, txsh_r;
    logic [3:0] rxcnt_r, txcnt_r;
    logic       rx_full_r, cts_chg_r, tx_busy_r, tx_load_r;
    logic       half_r;
    logic       clk1_rise, clk1_fall, cts_edge, wr_stb, rd_stb;
    logic       pending, cts_ok;
    logic [7:0] status_w;

    assign clk1_rise = clk1_s & ~clk1_d_r;
    assign clk1_fall = ~clk1_s & clk1_d_r;
    assign cts_edge  = cts_n_s ^ cts_d_r;
    assign wr_stb    = ~cs_n_s & cs_d_r & ~rnw_s;
    assign rd_stb    = ~cs_n_s & cs_d_r & rnw_s;
    assign pending   = rx_full_r | cts_chg_r;
    assign cts_ok    = ~ctrl_r[`CTRL_CTS_EN] | ctrl_r[`CTRL_LOOPM]
                       | ~cts_n_s;
    assign status_w  = {4'h0, ~cts_n_s, tx_busy_r, cts_chg_r, rx_full_r};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk1_d_r <= 1'b0;
            cts_d_r  <= 1'b1;
            cs_d_r   <= 1'b1;
        end
        else
        begin
            clk1_d_r <= clk1_s;
            cts_d_r  <= cts_n_s;
            cs_d_r   <= cs_n_s;
        end
    end

    // host writes to the six-bit register space
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r    <= 8'h00;
            vector_r  <= `VEC_RESET;
            txdata_r  <= 8'h00;
            tx_load_r <= 1'b0;
        end
        else
        begin
            tx_load_r <= 1'b0;
            if (wr_stb)
            begin
                unique case (addr_s)
                    `REG_TXDATA:
                    begin
                        txdata_r  <= pins.data_host_out;
                        tx_load_r <= 1'b1;
                    end
                    `REG_CTRL:   ctrl_r   <= pins.data_host_out;
                    `REG_VECTOR: vector_r <= pins.data_host_out;
                    default:     ;
                endcase
            end
        end
    end

    // clear-to-send change flag, set beats read clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cts_chg_r <= 1'b0;
        else if (cts_edge && ctrl_r[`CTRL_CTS_IE] && !ctrl_r[`CTRL_LOOPM])
            cts_chg_r <= 1'b1;
        else if (rd_stb && addr_s == `REG_STATUS)
            cts_chg_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // receiver: external clock on pin one, rising edge, lsb first
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rxsh_r    <= 8'h00;
            rxcnt_r   <= `CNT_ZERO;
            rxdata_r  <= 8'h00;
            rx_full_r <= 1'b0;
            rx_strobe <= 1'b0;
        end
        else
        begin
            rx_strobe <= 1'b0;
            if (clk1_rise)
            begin
                rxsh_r <= {rxd_s, rxsh_r[7:1]};
                rxcnt_r <= rxcnt_r + 4'h1;
                if (rxcnt_r == `BIT_LAST)
                begin
                    rxdata_r  <= {rxd_s, rxsh_r[7:1]};
                    rx_full_r <= 1'b1;
                    rx_strobe <= 1'b1;
                    rxcnt_r   <= `CNT_ZERO;
                end
            end
            else if (rd_stb && addr_s == `REG_RXDATA)
                rx_full_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // transmitter: shifts on falling edge of pin one, lsb first
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txsh_r    <= 8'hFF;
            txcnt_r   <= `CNT_ZERO;
            tx_busy_r <= 1'b0;
            pins.serial_out_chan_a <= 1'b1;
        end
        else
        begin
            if (tx_load_r && !tx_busy_r)
            begin
                txsh_r    <= txdata_r;
                tx_busy_r <= 1'b1;
                txcnt_r   <= `CNT_ZERO;
            end
            else if (tx_busy_r && clk1_fall && cts_ok)
            begin
                pins.serial_out_chan_a <= txsh_r[0];
                txsh_r  <= {1'b1, txsh_r[7:1]};
                txcnt_r <= txcnt_r + 4'h1;
                if (txcnt_r == `BIT_LAST)
                    tx_busy_r <= 1'b0;
            end
            else if (!tx_busy_r && clk1_fall)
                pins.serial_out_chan_a <= 1'b1;
            if (!ctrl_r[`CTRL_TX_EN] || ctrl_r[`CTRL_LOOPBK])
                pins.serial_out_chan_a <= 1'b1;
        end
    end
    assign tx_active = tx_busy_r;

    // ------------------------------------------------------------
    // bus drive, vector, daisy chain, clocks, loop control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pins.data_dev_out <= 8'h00;
            pins.data_dev_oe  <= 1'b0;
            pins.interrupt_request_n_oe <= 1'b0;
            pins.daisy_chain_n <= 1'b1;
        end
        else
        begin
            pins.interrupt_request_n_oe <= pending;
            pins.daisy_chain_n <= ~(ctrl_r[`CTRL_DAISY] & ~iack_n_s
                                    & ~pending);
            pins.data_dev_oe  <= 1'b0;
            pins.data_dev_out <= 8'h00;
            if (!iack_n_s && pending)
            begin
                pins.data_dev_oe <= 1'b1;
                pins.data_dev_out <= ctrl_r[`CTRL_VEC_MOD]
                    ? {vector_r[7:2], rx_full_r, cts_chg_r}
                    : vector_r;
            end
            else if (!cs_n_s && rnw_s)
            begin
                // latched at select so clear-on-read cannot alter it
                pins.data_dev_oe  <= 1'b1;
                pins.data_dev_out <= pins.data_dev_out;
                if (rd_stb)
                begin
                    unique case (addr_s)
                        `REG_RXDATA: pins.data_dev_out <= rxdata_r;
                        `REG_CTRL:   pins.data_dev_out <= ctrl_r;
                        `REG_STATUS: pins.data_dev_out <= status_w;
                        `REG_VECTOR: pins.data_dev_out <= vector_r;
                        default:     pins.data_dev_out <= 8'h00;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            half_r <= 1'b0;
            pins.loop_control_n  <= 1'b1;
            pins.loop_control_oe <= 1'b0;
        end
        else
        begin
            half_r <= ~half_r;
            pins.loop_control_oe <= ctrl_r[`CTRL_LOOPM];
            pins.loop_control_n  <= ~(ctrl_r[`CTRL_LOOPM]
                                      & ctrl_r[`CTRL_LC_ON]);
        end
    end
    assign pins.chan_clock_pin_two = half_r;
endmodule : dsc_device

// File: hdl/dsc_host.sv
// host cpu end: apb slave registers driving the cpu pins
`timescale 1ns/1ps
`include "dsc_cfg.svh"
module dsc_host
    import dsc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq_seen,
    dsc_if.host              pins
);
    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    host_st_t   st_r;
    logic [3:0] cnt_r;
    logic [13:0] cmd_r;
    logic [7:0] wdata_r, rdata_r;
    logic [1:0] irq_sync_r;
    logic       busy;
    logic       acc;

    assign busy = (st_r != HS_IDLE);
    assign acc  = psel & penable;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            wdata_r <= 8'h00;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                prdata <= 32'h0000_0000;
                unique case (paddr)
                    `H_RDATA:  prdata <= {24'h00_0000, rdata_r};
                    `H_STATUS: prdata <= {30'h0000_0000, irq_sync_r[1],
                                          busy};
                    `H_WDATA:  prdata <= {24'h00_0000, wdata_r};
                    `H_CMD:    prdata <= {18'h0_0000, cmd_r};
                    default:   pslverr <= 1'b1;
                endcase
            end
            // writes land only at the ready edge
            if (acc && pready && pwrite && paddr == `H_WDATA)
                wdata_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_sync_r <= 2'b00;
        else
            irq_sync_r <= {irq_sync_r[0], pins.interrupt_request_n_oe};
    end
    assign irq_seen = irq_sync_r[1];

    // ------------------------------------------------------------
    // cpu cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r    <= HS_IDLE;
            cnt_r   <= 4'h0;
            cmd_r   <= 14'h0000;
            rdata_r <= 8'h00;
            pins.addr <= 6'h00;
            pins.read_not_write <= 1'b1;
            pins.chip_select_n  <= 1'b1;
            pins.interrupt_ack_n <= 1'b1;
            pins.data_host_out  <= 8'h00;
            pins.data_host_oe   <= 1'b0;
        end
        else
        begin
            unique case (st_r)
                HS_IDLE:
                    if (acc && pready && pwrite && paddr == `H_CMD
                        && pwdata[`CMD_GO])
                    begin
                        cmd_r <= pwdata[13:0];
                        pins.addr <= pwdata[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
                        pins.read_not_write <= pwdata[`CMD_READ];
                        pins.data_host_out  <= wdata_r;
                        pins.data_host_oe   <= ~pwdata[`CMD_READ]
                                               & ~pwdata[`CMD_IACK];
                        st_r  <= HS_SETUP;
                        cnt_r <= 4'h0;
                    end
                HS_SETUP:
                begin
                    if (cmd_r[`CMD_IACK])
                        pins.interrupt_ack_n <= 1'b0;
                    else
                        pins.chip_select_n <= 1'b0;
                    st_r <= HS_STRB;
                end
                HS_STRB:
                begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == `STROBE_CYC)
                    begin
                        rdata_r <= pins.data_dev_oe ? pins.data_dev_out
                                                    : 8'h00;
                        st_r <= HS_DONE;
                    end
                end
                HS_DONE:
                begin
                    pins.chip_select_n   <= 1'b1;
                    pins.interrupt_ack_n <= 1'b1;
                    pins.data_host_oe    <= 1'b0;
                    cmd_r[`CMD_GO]       <= 1'b0;
                    st_r <= HS_IDLE;
                end
                default: st_r <= HS_IDLE;
            endcase
        end
    end
endmodule : dsc_host

// File: tb/dsc_asserts.sv
// pin assertions between the host and device ends
`timescale 1ns/1ps
module dsc_asserts
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic read_not_write,
    input wire logic chip_select_n,
    input wire logic interrupt_ack_n,
    input wire logic data_host_oe,
    input wire logic data_dev_oe,
    input wire logic interrupt_request_n_oe,
    input wire logic daisy_chain_n,
    input wire logic serial_out_chan_a,
    input wire logic chan_clock_pin_one,
    input wire logic chan_clock_pin_two
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------
    // data bus, acknowledge, link
    // ----------------------------
    float_idle_a: assert property (
        (chip_select_n && interrupt_ack_n)[*4] |-> !data_dev_oe)
        else $error("idle data bus driven");
    write_quiet_a: assert property (
        (!read_not_write && interrupt_ack_n)[*4] |-> !data_dev_oe)
        else $error("bus driven in write");
    read_drive_a: assert property (
        (!chip_select_n && read_not_write && interrupt_ack_n)[*5]
        |-> data_dev_oe) else $error("read not driven");
    ack_ignore_a: assert property (
        (!interrupt_ack_n && !interrupt_request_n_oe)[*4] |-> !data_dev_oe)
        else $error("ack driven without pending");
    ack_vector_a: assert property (
        (!interrupt_ack_n && interrupt_request_n_oe)[*5] |-> data_dev_oe)
        else $error("vector not driven");
    daisy_pass_a: assert property (
        $fell(daisy_chain_n) |-> !interrupt_request_n_oe)
        else $error("ack passed while pending");
    daisy_idle_a: assert property (
        interrupt_ack_n[*4] |-> daisy_chain_n)
        else $error("daisy low without ack");
    bus_fight_a: assert property (
        !(data_dev_oe && data_host_oe)) else $error("bus contention");
    tx_fall_a: assert property (
        $changed(serial_out_chan_a) |-> !$past(chan_clock_pin_one))
        else $error("tx moved off falling edge");
    half_clock_a: assert property (
        $past(presetn) |-> chan_clock_pin_two != $past(chan_clock_pin_two))
        else $error("pin two not half rate");
    reset_state_a: assert property (disable iff (1'b0)
        !presetn |-> !data_dev_oe && !interrupt_request_n_oe
        && daisy_chain_n && serial_out_chan_a) else $error("reset state");
endmodule : dsc_asserts

// File: tb/test_dual_serial_ctrl_pin_interface.sv
// self-checking bench joining the host and device ends
`timescale 1ns/1ps
`include "dsc_cfg.svh"
module test_dual_serial_ctrl_pin_interface
    import dsc_pkg::*;
;
    // --------------------
    // signals and model
    // --------------------
    logic        pclk = 1'b0;
    logic        presetn = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_seen;
    logic        rx_strobe;
    logic        tx_active;
    logic        run_ck = 1'b0;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  b;
    logic [7:0]  w;
    logic [7:0]  vec = 8'h0F;
    logic [7:0]  modes [3] = '{8'h03, 8'h05, 8'h00};
    logic        hit;
    logic        oe_seen = 1'b0;
    logic        daisy_seen = 1'b0;
    logic        smp [$];
    int          mismatches = 0;
    int          n_compared = 0;
    int          seed = 74;
    int          n_rx = 0;
    dsc_if       bus();

    always #4 pclk = ~pclk;
    always #32 bus.chan_clock_pin_one = run_ck & ~bus.chan_clock_pin_one;

    always @(posedge pclk)
    begin
        if (bus.data_dev_oe === 1'b1)
            oe_seen <= 1'b1;
        if (bus.daisy_chain_n === 1'b0)
            daisy_seen <= 1'b1;
        if (rx_strobe === 1'b1)
            n_rx <= n_rx + 1;
    end

    dsc_device i_dsc_device
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pins      (bus),
        .rx_strobe (rx_strobe),
        .tx_active (tx_active)
    );
    dsc_host i_dsc_host
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .irq_seen (irq_seen),
        .pins     (bus)
    );
    dsc_asserts u_chk
    (
        .pclk                   (pclk),
        .presetn                (presetn),
        .read_not_write         (bus.read_not_write),
        .chip_select_n          (bus.chip_select_n),
        .interrupt_ack_n        (bus.interrupt_ack_n),
        .data_host_oe           (bus.data_host_oe),
        .data_dev_oe            (bus.data_dev_oe),
        .interrupt_request_n_oe (bus.interrupt_request_n_oe),
        .daisy_chain_n          (bus.daisy_chain_n),
        .serial_out_chan_a      (bus.serial_out_chan_a),
        .chan_clock_pin_one     (bus.chan_clock_pin_one),
        .chan_clock_pin_two     (bus.chan_clock_pin_two)
    );

    // --------------------
    // tasks
    // --------------------
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w_en, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w_en;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n == 20)
            mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // kind bit 0 read, bit 1 acknowledge
    task automatic dev_op(input logic [5:0] a, input logic [7:0] wd,
                          input logic [1:0] kind);
        int n;
        n = 0;
        oe_seen = 1'b0;
        daisy_seen = 1'b0;
        apb(1'b1, `H_WDATA, {24'h0, wd});
        apb(1'b1, `H_CMD, {18'h0, a, 5'h0, kind, 1'b1});
        do
        begin
            apb(1'b0, `H_STATUS, 32'h0);
            n++;
        end
        while (rd[0] !== 1'b0 && n < 50);
        if (n == 50)
            mismatches++;
        apb(1'b0, `H_RDATA, 32'h0);
    endtask : dev_op

    // runs n link clock periods, sampling the line at each rise
    task automatic run_frame(input logic [7:0] d, input int n);
        smp.delete();
        @(posedge pclk);
        bus.serial_in_chan_a <= d[0];
        run_ck <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge bus.chan_clock_pin_one);
            smp.push_back(bus.serial_out_chan_a);
            @(negedge bus.chan_clock_pin_one);
            @(posedge pclk);
            bus.serial_in_chan_a <= d[(i + 1) % 8];
        end
        run_ck <= 1'b0;
    endtask : run_frame

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // --------------------
    // sequence
    // --------------------
    initial
    begin
        presetn <= 1'b0;
        bus.serial_in_chan_a = 1'b1;
        bus.clear_to_send_n = 1'b1;
        bus.chan_clock_pin_one = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        dev_op(`REG_VECTOR, 8'h00, 2'b01);
        chk("vector", rd[7:0], vec);
        dev_op(`REG_STATUS, 8'h00, 2'b01);
        chk("status", rd[7:0], 8'h00);
        apb(1'b0, `H_LINK, 32'h0);
        chk("unmapped", err, 1'b1);
        repeat (3)
        begin
            vec = 8'($random(seed));
            dev_op(`REG_VECTOR, vec, 2'b00);
            dev_op(`REG_VECTOR, 8'h00, 2'b01);
            chk("readback", rd[7:0], vec);
        end
        dev_op(`REG_CTRL, 8'h80, 2'b00);
        dev_op(`REG_CTRL, 8'h00, 2'b01);
        chk("ctrl", rd[7:0], 8'h80);
        dev_op(6'h00, 8'h00, 2'b10);
        chk("ack float", oe_seen, 1'b0);
        chk("daisy pass", daisy_seen, 1'b1);
        $display("test registers and idle ack done");
        b = 8'($random(seed));
        run_frame(b, 8);
        repeat (10) @(posedge pclk);
        apb(1'b0, `H_STATUS, 32'h0);
        chk("irq set", rd[1], 1'b1);
        chk("irq pin", irq_seen, 1'b1);
        chk("rx strobe", n_rx, 1);
        dev_op(6'h00, 8'h00, 2'b10);
        chk("vector fixed", rd[7:0], vec);
        chk("daisy held", daisy_seen, 1'b0);
        dev_op(`REG_CTRL, 8'hC0, 2'b00);
        dev_op(6'h00, 8'h00, 2'b10);
        chk("vector mod", rd[7:0], {vec[7:2], 2'b10});
        dev_op(`REG_RXDATA, 8'h00, 2'b01);
        chk("rx byte", rd[7:0], b);
        repeat (6) @(posedge pclk);
        apb(1'b0, `H_STATUS, 32'h0);
        chk("irq clear", rd[1], 1'b0);
        $display("test receive and vector done");
        dev_op(`REG_CTRL, 8'h20, 2'b00);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge pclk);
            bus.clear_to_send_n <= k[0];
            repeat (8) @(posedge pclk);
            apb(1'b0, `H_STATUS, 32'h0);
            chk("cts irq", rd[1], 1'b1);
            dev_op(`REG_STATUS, 8'h00, 2'b01);
            chk("cts status", rd[7:0], {4'h0, ~k[0], 3'b010});
            repeat (6) @(posedge pclk);
            apb(1'b0, `H_STATUS, 32'h0);
            chk("cts clear", rd[1], 1'b0);
        end
        $display("test clear to send done");
        dev_op(`REG_CTRL, 8'h01, 2'b00);
        b = 8'($random(seed));
        dev_op(`REG_TXDATA, b, 2'b00);
        chk("tx busy", tx_active, 1'b1);
        run_frame(8'hFF, 10);
        for (int k = 0; k < 8; k++)
            w[k] = smp[k + 1];
        chk("tx byte", w, b);
        chk("tx done", tx_active, 1'b0);
        chk("tx idle mark", smp[9], 1'b1);
        for (int m = 0; m < 3; m++)
        begin
            dev_op(`REG_CTRL, modes[m], 2'b00);
            dev_op(`REG_TXDATA, 8'h00, 2'b00);
            run_frame(8'hFF, 10);
            hit = 1'b1;
            foreach (smp[i])
                hit = hit & smp[i];
            chk("tx mark", hit, 1'b1);
        end
        $display("test transmit done");
        for (int k = 0; k < 2; k++)
        begin
            dev_op(`REG_CTRL, k[0] ? 8'h18 : 8'h08, 2'b00);
            repeat (4) @(posedge pclk);
            chk("loop oe", bus.loop_control_oe, 1'b1);
            chk("loop level", bus.loop_control_n, !k[0]);
        end
        $display("test loop control done");
        final_report();
    end

    initial
    begin
        #200000;
        mismatches++;
        final_report();
    end
endmodule : test_dual_serial_ctrl_pin_interface
